/* File: rtl/fmt_flash_timing_current_limits.sv */
// Behaviour
// [RULE1] timing bit 7: 0 monitor adjusts current down only (default), 1 up and down
// [RULE2] timing bit 6: 0 level strobe, 1 edge strobe; edge is the reset default
// [RULE3] ramp field bits 5:3: 256 us at 000, doubling per code to 32.768 ms
// [RULE4] time-out bits 2:0: 50 ms per step from 50 ms to 400 ms, default 150 ms
// [RULE5] max torch bits 6:4 pick 23.04 to 187.10 mA, default code 111
// [RULE6] max flash bits 3:0 pick total limit in 93.75 mA steps, default 1111
// [RULE7] with both leds active, second code equals max code minus first code
// [RULE8] max below first code: first clamped to max, second led switched off
// [RULE9] flash lasting the selected time-out is ended and current stops
module fmt_flash_timing_current_limits #(
	parameter int TICK_CYCLES  = fmt_pkg::TICK_CYCLES,
	parameter int RAMP_BASE_US = fmt_pkg::RAMP_BASE_US,
	parameter int TOUT_STEP_US = fmt_pkg::TOUT_STEP_US
)(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrEn,
	input  wire logic       regRdEn,
	output logic      [7:0] regRdData,
	input  wire logic       flashModeEn,
	input  wire logic       strobe,
	output logic            flashActive,
	output logic            flashRamping,
	output logic            flashTimedOut,
	output logic            monitorUpDown,
	output logic            strobeEdgeMode,
	output logic      [2:0] maxTorchCode,
	output logic      [6:0] firstLedCode,
	output logic      [6:0] secondLedCode,
	output logic            secondLedOff,
	output logic            shortFaultEn
);

	localparam int TW = fmt_pkg::TIME_W;

	// ************************************************************
	// registers
	// ************************************************************
	logic [7:0] timing_q;
	logic [7:0] maxCur_q;
	logic [7:0] first_q;

	wire selTiming = (regAddr == fmt_pkg::ADDR_FLASH_TIMING);
	wire selMax    = (regAddr == fmt_pkg::ADDR_MAX_CURRENT);
	wire selFirst  = (regAddr == fmt_pkg::ADDR_FIRST_FLASH);

	// writes anywhere else are dropped, so stray addresses cannot disturb the flash setup
	wire wrTiming  = regWrEn && selTiming;
	wire wrMax     = regWrEn && selMax;
	wire wrFirst   = regWrEn && selFirst;

	// read data is registered, so a read and a write in one cycle return the old value
	wire [7:0] rdMux = selTiming ? timing_q :
	                   selMax    ? maxCur_q :
	                   selFirst  ? first_q  : fmt_pkg::UNMAPPED_READ;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			timing_q  <= fmt_pkg::RST_FLASH_TIMING; // [RULE1] [RULE2] [RULE3] [RULE4]
			maxCur_q  <= fmt_pkg::RST_MAX_CURRENT;  // [RULE5] [RULE6]
			first_q   <= fmt_pkg::RST_FIRST_FLASH;
			regRdData <= fmt_pkg::UNMAPPED_READ;
		end
		else
		begin
			if (wrTiming)
				timing_q <= regWrData;
			if (wrMax)
				maxCur_q <= regWrData;
			if (wrFirst)
				first_q <= regWrData;
			if (regRdEn)
				regRdData <= rdMux;
		end
	end

	// ************************************************************
	// field decode
	// ************************************************************
	wire       monBit    = timing_q[fmt_pkg::BIT_MON_UPDOWN];
	wire       edgeMode  = timing_q[fmt_pkg::BIT_STROBE_EDGE];
	wire [2:0] rampCode  = timing_q[fmt_pkg::RAMP_HI:fmt_pkg::RAMP_LO];
	wire [2:0] toutCode  = timing_q[fmt_pkg::TOUT_HI:fmt_pkg::TOUT_LO];
	wire       strobeUse = first_q[fmt_pkg::BIT_STROBE_PIN];
	wire [2:0] torchCode = maxCur_q[fmt_pkg::TORCH_HI:fmt_pkg::TORCH_LO];
	wire       shortBit  = maxCur_q[fmt_pkg::BIT_SHORT_EN];

	wire [TW-1:0] rampUs = TW'(RAMP_BASE_US) << rampCode; // [RULE3]
	wire [TW-1:0] toutUs = TW'(TOUT_STEP_US * (int'(toutCode) + 1)); // [RULE4]

	// ************************************************************
	// current split
	// ************************************************************
	// the second led gets what the first leaves of the shared limit
	wire [6:0] maxFine  = {maxCur_q[fmt_pkg::MAXF_HI:fmt_pkg::MAXF_LO], fmt_pkg::FINE_FILL}; // [RULE6]
	wire [6:0] firstReq = first_q[fmt_pkg::FIRST_HI:fmt_pkg::FIRST_LO];
	wire       overMax  = (maxFine < firstReq);
	wire [6:0] firstEff = overMax ? maxFine : firstReq; // [RULE8]
	wire [6:0] secondEff = overMax ? 7'h00 : maxFine - firstReq; // [RULE7] [RULE8]

	// ************************************************************
	// flash sequencing
	// ************************************************************
	fmt_pkg::fmt_flash_t state_q;
	fmt_pkg::fmt_flash_t state_d;
	logic strobe_q;
	logic modeEn_q;

	// without the strobe pin the flash follows the mode bit written over the bus
	wire trigLevel = strobeUse ? (strobe && flashModeEn) : flashModeEn;
	// a strobe already high when the pin is enabled is not an edge
	wire trigRise  = strobeUse ? (strobe && !strobe_q && flashModeEn) : (flashModeEn && !modeEn_q);
	wire start     = edgeMode ? trigRise : trigLevel; // [RULE2]
	wire hold      = edgeMode ? flashModeEn : trigLevel; // [RULE2]

	// ramp and steady-on both drive current; decoded for the present and the next state
	function automatic logic isLit(input fmt_pkg::fmt_flash_t s);
		return (s == fmt_pkg::FL_RAMP) || (s == fmt_pkg::FL_ON);
	endfunction : isLit

	wire running = isLit(state_q);
	wire rampDone;
	wire toutDone;

	fmt_us_timer #(
		.CNT_W       (TW),
		.TICK_CYCLES (TICK_CYCLES)
	) u_ramp (
		.clk     (clk),
		.rst     (rst),
		.run     (state_q == fmt_pkg::FL_RAMP),
		.limitUs (rampUs),
		.expired (rampDone)
	);

	// spans ramp and on, so a long ramp eats into the on time rather than extending the flash
	fmt_us_timer #(
		.CNT_W       (TW),
		.TICK_CYCLES (TICK_CYCLES)
	) u_tout (
		.clk     (clk),
		.rst     (rst),
		.run     (running),
		.limitUs (toutUs),
		.expired (toutDone)
	);

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			fmt_pkg::FL_IDLE:
				if (start)
					state_d = fmt_pkg::FL_RAMP;
			fmt_pkg::FL_RAMP:
				if (!hold)
					state_d = fmt_pkg::FL_IDLE;
				else if (toutDone)
					state_d = fmt_pkg::FL_EXPIRED; // [RULE9]
				else if (rampDone)
					state_d = fmt_pkg::FL_ON;
			fmt_pkg::FL_ON:
				if (!hold)
					state_d = fmt_pkg::FL_IDLE;
				else if (toutDone)
					state_d = fmt_pkg::FL_EXPIRED; // [RULE9]
			// stays dark until the trigger is released so a held strobe cannot relight
			fmt_pkg::FL_EXPIRED:
				if (!trigLevel)
					state_d = fmt_pkg::FL_IDLE;
			default:
				state_d = fmt_pkg::FL_IDLE;
		endcase
	end

	wire nextRunning = isLit(state_d);
	wire expireEvent = (state_d == fmt_pkg::FL_EXPIRED) && (state_q != fmt_pkg::FL_EXPIRED);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_q        <= fmt_pkg::FL_IDLE;
			strobe_q       <= 1'b0;
			modeEn_q       <= 1'b0;
			flashActive    <= 1'b0;
			flashRamping   <= 1'b0;
			flashTimedOut  <= 1'b0;
			// copies start from the register reset image so they agree from the first edge
			monitorUpDown  <= fmt_pkg::RST_FLASH_TIMING[fmt_pkg::BIT_MON_UPDOWN]; // [RULE1]
			strobeEdgeMode <= fmt_pkg::RST_FLASH_TIMING[fmt_pkg::BIT_STROBE_EDGE]; // [RULE2]
			maxTorchCode   <= fmt_pkg::RST_MAX_CURRENT[fmt_pkg::TORCH_HI:fmt_pkg::TORCH_LO]; // [RULE5]
			shortFaultEn   <= fmt_pkg::RST_MAX_CURRENT[fmt_pkg::BIT_SHORT_EN];
			firstLedCode   <= 7'h00;
			secondLedCode  <= 7'h00;
			secondLedOff   <= 1'b1;
		end
		else
		begin
			state_q        <= state_d;
			strobe_q       <= strobe;
			modeEn_q       <= flashModeEn;
			flashActive    <= nextRunning; // [RULE9]
			flashRamping   <= (state_d == fmt_pkg::FL_RAMP); // [RULE3]
			flashTimedOut  <= expireEvent; // [RULE9]
			monitorUpDown  <= monBit; // [RULE1]
			strobeEdgeMode <= edgeMode; // [RULE2]
			maxTorchCode   <= torchCode; // [RULE5]
			shortFaultEn   <= shortBit;
			// no current is driven outside an active flash
			firstLedCode   <= nextRunning ? firstEff : 7'h00; // [RULE8] [RULE9]
			secondLedCode  <= nextRunning ? secondEff : 7'h00; // [RULE7] [RULE9]
			secondLedOff   <= !nextRunning || overMax || (secondEff == 7'h00); // [RULE8]
		end
	end

endmodule : fmt_flash_timing_current_limits

/* File: rtl/fmt_pkg.sv */
package fmt_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] ADDR_FLASH_TIMING = 8'h04;
	localparam logic [7:0] ADDR_MAX_CURRENT  = 8'h05;
	localparam logic [7:0] ADDR_FIRST_FLASH  = 8'h06;

	localparam logic [7:0] RST_FLASH_TIMING  = 8'h42;
	localparam logic [7:0] RST_MAX_CURRENT   = 8'h7F;
	localparam logic [7:0] RST_FIRST_FLASH   = 8'h7F;
	localparam logic [7:0] UNMAPPED_READ     = 8'hFF;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int BIT_MON_UPDOWN  = 7;
	localparam int BIT_STROBE_EDGE = 6;
	localparam int RAMP_HI         = 5;
	localparam int RAMP_LO         = 3;
	localparam int TOUT_HI         = 2;
	localparam int TOUT_LO         = 0;
	localparam int BIT_SHORT_EN    = 7;
	localparam int TORCH_HI        = 6;
	localparam int TORCH_LO        = 4;
	localparam int MAXF_HI         = 3;
	localparam int MAXF_LO         = 0;
	localparam int BIT_STROBE_PIN  = 7;
	localparam int FIRST_HI        = 6;
	localparam int FIRST_LO        = 0;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_HZ         = 100_000_000;
	localparam int HZ_PER_MHZ     = 1_000_000;
	localparam int TICK_CYCLES    = (CLK_HZ + HZ_PER_MHZ - 1) / HZ_PER_MHZ;
	localparam int RAMP_BASE_US   = 256;
	localparam int TOUT_STEP_US   = 50_000;
	localparam int TIME_W         = 19;

	// the max flash code is on a scale eight times coarser than the led code
	localparam int FINE_SHIFT     = 3;
	localparam logic [2:0] FINE_FILL = 3'h7;

	typedef enum logic [1:0]
	{
		FL_IDLE    = 2'b00,
		FL_RAMP    = 2'b01,
		FL_ON      = 2'b11,
		FL_EXPIRED = 2'b10
	} fmt_flash_t;

endpackage : fmt_pkg

/* File: rtl/fmt_us_timer.sv */
module fmt_us_timer #(
	parameter int CNT_W       = 19,
	parameter int TICK_CYCLES = 100
)(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             run,
	input  wire logic [CNT_W-1:0] limitUs,
	output logic                  expired
);

	localparam int DIV_W = $clog2(TICK_CYCLES + 1);

	logic [DIV_W-1:0] div_q;
	logic [CNT_W-1:0] count_q;
	wire              tick    = (div_q == DIV_W'(TICK_CYCLES - 1));
	wire              reached = (count_q >= limitUs);

	// count restarts whenever run drops so every flash gets a full interval
	always_ff @(posedge clk)
	begin
		if (rst || !run)
		begin
			div_q   <= '0;
			count_q <= '0;
			expired <= 1'b0;
		end
		else
		begin
			div_q   <= tick ? '0 : div_q + 1'b1;
			if (tick && !reached)
				count_q <= count_q + 1'b1;
			expired <= reached;
		end
	end

endmodule : fmt_us_timer

/* File: verif/fmt_flash_assertions.sv */
module fmt_flash_assertions (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regWrEn,
	input wire logic       regRdEn,
	input wire logic [7:0] regRdData,
	input wire logic       flashActive,
	input wire logic       flashRamping,
	input wire logic       flashTimedOut,
	input wire logic       monitorUpDown,
	input wire logic       strobeEdgeMode,
	input wire logic [2:0] maxTorchCode,
	input wire logic [6:0] firstLedCode,
	input wire logic [6:0] secondLedCode,
	input wire logic       secondLedOff
);
	// ****
	// copies follow the registers one edge after the write lands
	// ****
	a_timing_copy: assert property (@(posedge clk) disable iff (rst)
		(regWrEn && regAddr == 8'h04) ##1 !regWrEn |=> {monitorUpDown, strobeEdgeMode} == $past(regWrData[7:6], 2))
		else $error("timing copy wrong");
	a_torch_copy: assert property (@(posedge clk) disable iff (rst)
		(regWrEn && regAddr == 8'h05) ##1 !regWrEn |=> maxTorchCode == $past(regWrData[6:4], 2))
		else $error("torch copy wrong");
	a_unmapped_read: assert property (@(posedge clk) disable iff (rst)
		regRdEn && !(regAddr inside {[8'h04:8'h06]}) |=> regRdData == 8'hFF)
		else $error("unmapped read not all ones");
	// no disable here: it looks at the reset itself
	a_reset_defaults: assert property (@(posedge clk) rst ##1 rst |=> strobeEdgeMode && !monitorUpDown
		&& maxTorchCode == 3'h7 && !flashActive) else $error("reset defaults wrong");
	a_second_off: assert property (@(posedge clk) disable iff (rst)
		flashActive |-> secondLedOff == (secondLedCode == 7'h00)) else $error("second off mismatch");
	a_idle_codes: assert property (@(posedge clk) disable iff (rst)
		!flashActive [*2] |-> firstLedCode == 7'h00 && secondLedCode == 7'h00) else $error("codes not zero when idle");
	a_timeout_ends: assert property (@(posedge clk) disable iff (rst)
		flashTimedOut |-> $past(flashActive) ##1 (!flashTimedOut && !flashActive)) else $error("time-out pulse wrong");
	a_ramp_inside: assert property (@(posedge clk) disable iff (rst)
		flashRamping |-> flashActive) else $error("ramp outside flash");
endmodule : fmt_flash_assertions

bind fmt_flash_timing_current_limits fmt_flash_assertions chk (.clk(clk), .rst(rst), .regAddr(regAddr),
	.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .flashActive(flashActive),
	.flashRamping(flashRamping), .flashTimedOut(flashTimedOut), .monitorUpDown(monitorUpDown),
	.strobeEdgeMode(strobeEdgeMode), .maxTorchCode(maxTorchCode), .firstLedCode(firstLedCode),
	.secondLedCode(secondLedCode), .secondLedOff(secondLedOff));

/* File: verif/fmt_host_model.sv */
module fmt_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] regRdData,
	output logic      [7:0] regAddr,
	output logic      [7:0] regWrData,
	output logic            regWrEn,
	output logic            regRdEn
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// host side of the register port, one strobe per access
	// ****
	initial
	begin
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		#1 d = regRdData;
	endtask : rd
endmodule : fmt_host_model

/* File: verif/fmt_flash_timing_current_limits_bench.sv */
module fmt_flash_timing_current_limits_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst = 1'b1, flashModeEn = 1'b0, strobe = 1'b0, fa, fr, fto, mon, edg, off, sfe;
	logic [7:0] addr, wd, rdd, v;
	logic       we, re;
	logic [2:0] torch;
	logic [6:0] c1, c2, ef, es, f;
	logic [3:0] m;
	int failures = 0, checks_done = 0, i, k, nr;
	logic [31:0] seed = 32'h0000_003F;
	always #5 clk = ~clk;
	fmt_host_model host (.clk(clk), .regRdData(rdd), .regAddr(addr), .regWrData(wd), .regWrEn(we), .regRdEn(re));
	fmt_flash_timing_current_limits #(.TICK_CYCLES(2), .RAMP_BASE_US(4), .TOUT_STEP_US(50)) uut (.clk(clk),
		.rst(rst), .regAddr(addr), .regWrData(wd), .regWrEn(we), .regRdEn(re), .regRdData(rdd),
		.flashModeEn(flashModeEn), .strobe(strobe), .flashActive(fa), .flashRamping(fr), .flashTimedOut(fto),
		.monitorUpDown(mon), .strobeEdgeMode(edg), .maxTorchCode(torch), .firstLedCode(c1), .secondLedCode(c2),
		.secondLedOff(off), .shortFaultEn(sfe));
	// ****
	// helpers
	// ****
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	// max flash code sits on a scale eight times coarser than the led code
	function automatic logic [13:0] split(input logic [3:0] mx, input logic [6:0] fl);
		logic [6:0] fine;
		fine = {mx, 3'h7};
		return (fine < fl) ? {fine, 7'h00} : {fl, fine - fl};
	endfunction : split
	task automatic cmpv(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : cmpv
	// durations carry a little slack for the tick counter start-up
	task automatic cmpn(input string n, input int e, input int g, input int tol);
		checks_done++;
		if (g < e - tol || g > e + tol)
		begin
			failures++;
			$display("[FAIL] %s expected %0d seen %0d", n, e, g);
		end
	endtask : cmpn
	task automatic final_report();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	initial
	begin
		#400us;
		failures++;
		final_report();
	end
	// ****
	// tests
	// ****
	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		host.rd(8'h04, v);
		cmpv("timing reset", 8'h42, v);
		host.rd(8'h05, v);
		cmpv("max reset", 8'h7F, v);
		host.rd(8'h07, v);
		cmpv("unmapped read", 8'hFF, v);
		cmpv("edge default", 8'h01, {7'h00, edg});
		$display("test reset done");
		for (i = 0; i < 6; i++)
		begin
			seed = xs(seed);
			addr_case: host.wr(8'h04 + 8'(seed[1:0] % 3), seed[15:8]);
			host.wr(8'h20, 8'h00);
			host.rd(8'h04 + 8'(seed[1:0] % 3), v);
			cmpv("readback", seed[15:8], v);
			if (seed[1:0] % 3 == 0) cmpv("timing copy", seed[15:14], {mon, edg});
			if (seed[1:0] % 3 == 1) cmpv("torch copy", seed[14:12], torch);
			if (seed[1:0] % 3 == 1) cmpv("short enable copy", {7'h00, seed[15]}, {7'h00, sfe});
		end
		host.rd(8'h20, v);
		cmpv("ignored write", 8'hFF, v);
		$display("test registers done");
		for (i = 0; i < 8; i++)
		begin
			seed = xs(seed);
			m = (i == 1) ? 4'h3 : seed[3:0];
			f = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : seed[10:4];
			host.wr(8'h04, {seed[12:11], 3'(i >> 1), 3'(i)});
			host.wr(8'h05, {1'b0, seed[15:13], m});
			host.wr(8'h06, {1'b0, f});
			@(posedge clk) flashModeEn <= 1'b1;
			k = 0;
			do @(posedge clk); while (fa !== 1'b1 && ++k < 20);
			#1 {ef, es} = split(m, f);
			cmpv("first code", {1'b0, ef}, {1'b0, c1});
			cmpv("second code", {1'b0, es}, {1'b0, c2});
			k = 0;
			nr = 0;
			while (fto !== 1'b1 && k < 2000)
			begin
				nr += (fr === 1'b1);
				@(posedge clk);
				#1 k++;
			end
			cmpn("ramp cycles", (4 << (i >> 1)) * 2, nr, 3);
			cmpn("flash cycles", 100 * (i + 1), k, 4);
			@(posedge clk) flashModeEn <= 1'b0;
			repeat (3) @(posedge clk);
		end
		$display("test flash done");
		// strobe pin enabled: level mode (i = 0) ends on strobe low, edge mode (i = 1) holds on
		for (i = 0; i < 2; i++)
		begin
			host.wr(8'h04, {1'b0, 1'(i), 6'h00});
			host.wr(8'h06, 8'h85);
			@(posedge clk) flashModeEn <= 1'b1;
			repeat (3) @(posedge clk);
			#1 cmpv("no flash without strobe", 8'h00, {7'h00, fa});
			@(posedge clk) strobe <= 1'b1;
			repeat (2) @(posedge clk);
			#1 cmpv("strobe starts flash", 8'h01, {7'h00, fa});
			@(posedge clk) strobe <= 1'b0;
			repeat (2) @(posedge clk);
			#1 cmpv("after strobe low", {7'h00, 1'(i)}, {7'h00, fa});
			@(posedge clk) flashModeEn <= 1'b0;
			repeat (2) @(posedge clk);
			#1 cmpv("mode off ends flash", 8'h00, {6'h00, fa, fto});
		end
		$display("test strobe done");
		final_report();
	end
endmodule : fmt_flash_timing_current_limits_bench
